// [bench/rmmc_host_model.sv]
// Purpose: Host terminal on the serial data port
// Assumes: Bytes are already framed by a UART
// Notes:   Slow mode throttles acceptance of reply bytes
`timescale 1ns/1ps
`default_nettype none
module rmmc_host_model
   import rmmc_pkg::*;
(
   input wire logic        clk,
   input wire rmmc_byte_t  host_tx,
   input wire logic        host_rx_ready,
   output rmmc_byte_t      host_rx,
   output logic            host_tx_ready
);
   logic       slow;
   int         n;
   logic [7:0] got_q[$];
   initial begin
      slow = 1'b0;
      n = 0;
      host_rx = '0;
      host_tx_ready = 1'b1;
   end
   always @(posedge clk) begin
      n <= n + 1;
      host_tx_ready <= !slow || n[1];
      // The reply pulse is already acknowledged when it stands
      if (host_tx.valid === 1'b1) got_q.push_back(host_tx.data);
   end
   // Idle data shows the inverse so stale bytes never look valid
   task automatic send(input logic [7:0] b);
      int i;
      @(posedge clk);
      host_rx <= '{1'b1, b};
      // Byte stands until the edge at which ready is seen high
      @(posedge clk);
      for (i = 0; i < 100 && host_rx_ready !== 1'b1; i++) @(posedge clk);
      host_rx <= '{1'b0, ~b};
   endtask
endmodule // rmmc_host_model
`default_nettype wire

// [bench/rmmc_monitor.sv]
// Purpose: Port-level assertions for the mode controller
// Assumes: Sees only top-level ports; bound below
// Notes:   Command-mode output checks skip the first cycle of command mode
`timescale 1ns/1ps
`default_nettype none
`include "rmmc_defs.svh"
module rmmc_monitor
   import rmmc_pkg::*;
#(
   parameter int GUARD_CYCLES = 20,
   parameter int CYCLE_CYCLES = 10
) (
   input wire logic                    clk,
   input wire logic                    rst,
   input wire rmmc_byte_t              radio_tx,
   input wire rmmc_byte_t              user_rx,
   input wire rmmc_leds_t              leds,
   input wire logic [31:0]             data_baud,
   input wire logic [31:0]             diag_baud,
   input wire logic                    sync_source,
   input wire logic                    forward_en,
   input wire logic                    local_endpoint,
   input wire logic [1:0]              role,
   input wire logic [7:0]              network_type,
   input wire logic                    command_mode,
   input wire logic [`RMMC_ADDR_W-1:0] reg_addr,
   input wire logic [31:0]             reg_wdata,
   input wire logic                    reg_write,
   input wire logic                    reg_read,
   input wire logic [31:0]             reg_rdata
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   a_cmd_offline:
      assert property (command_mode && $past(command_mode) |-> !radio_tx.valid && !user_rx.valid)
      else $error("user data moved in command mode");
   a_cmd_dark:
      assert property (command_mode && $past(command_mode) |-> !leds.tx && !leds.rx_sync
         && leds.strength == 3'h0) else $error("indicator lit in command mode");
   a_diag_rate:
      assert property (!$past(rst) |-> diag_baud == `RMMC_DIAG_BAUD)
      else $error("diagnostic rate wrong");
   a_baud_range:
      assert property (!$past(rst) |-> data_baud >= `RMMC_MIN_BAUD
         && data_baud <= `RMMC_MAX_BAUD) else $error("data rate out of range");
   a_role_legal:
      assert property (role != 2'h3) else $error("illegal role");
   a_master_sync:
      assert property (!$past(rst) && role == RMMC_ROLE_MASTER |-> sync_source)
      else $error("master not sync source");
   a_rep_fwd:
      assert property (role == RMMC_ROLE_REPEATER && !command_mode |-> forward_en && !sync_source)
      else $error("repeater does not forward");
   a_end_local:
      assert property (role == RMMC_ROLE_ENDPOINT |-> local_endpoint && !sync_source)
      else $error("endpoint role wrong");
   a_rdata_once:
      assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   a_unmapped_zero:
      assert property (reg_read && reg_addr > 4'h6 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_role_write:
      assert property (command_mode && reg_write && reg_addr == `RMMC_OFF_ROLE
         && reg_wdata < 32'h3 |=> role == $past(reg_wdata[1:0])) else $error("role not written");
   a_type_write:
      assert property (command_mode && reg_write && reg_addr == `RMMC_OFF_NTYPE
         |=> network_type == $past(reg_wdata[7:0])) else $error("type not written");
   c_to_data: cover property (command_mode ##1 !command_mode);
   c_to_cmd: cover property (!command_mode ##1 command_mode);
   c_fwd: cover property (!command_mode && radio_tx.valid);
endmodule // rmmc_monitor

bind rmmc_top rmmc_monitor #(.GUARD_CYCLES(GUARD_CYCLES), .CYCLE_CYCLES(CYCLE_CYCLES)) mon_u (
   .clk, .rst, .radio_tx, .user_rx, .leds, .data_baud, .diag_baud, .sync_source, .forward_en,
   .local_endpoint, .role, .network_type, .command_mode, .reg_addr, .reg_wdata, .reg_write,
   .reg_read, .reg_rdata);
`default_nettype wire

// [bench/tb.sv]
// Purpose: Self-checking bench for the mode controller
// Assumes: Guard and cycle counts shortened to 20 and 10
// Notes:   Queues model forwarded traffic and reply text
`timescale 1ns/1ps
`default_nettype none
`include "rmmc_defs.svh"
module tb
   import rmmc_pkg::*;
;
   localparam int GRD = 20;
   logic        clk, rst, btn, hrr, htr, wr_s, rd_s, lda, r485, ssrc, fwd, lep, cmd;
   rmmc_byte_t  hrx, htx, rtx, rrx, urx;
   rmmc_radio_t radio;
   rmmc_leds_t  leds;
   logic [31:0] dbaud, gbaud, wd, rdat;
   logic [7:0]  ntype, rq[$], eq[$], uq[$];
   logic [3:0]  addr;
   logic [1:0]  role;
   int          fail_count = 0, n_tests = 0, lv[$];
   rmmc_top #(.GUARD_CYCLES(GRD), .CYCLE_CYCLES(10)) dut_u (
      .clk, .rst, .config_button(btn), .host_rx(hrx), .host_rx_ready(hrr), .host_tx(htx),
      .host_tx_ready(htr), .radio_tx(rtx), .radio_rx(rrx), .user_rx(urx), .radio,
      .local_device_attached(lda), .leds, .use_rs485(r485), .data_baud(dbaud),
      .diag_baud(gbaud), .sync_source(ssrc), .forward_en(fwd), .local_endpoint(lep), .role,
      .network_type(ntype), .command_mode(cmd), .reg_addr(addr), .reg_wdata(wd),
      .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdat));
   rmmc_host_model host_u (.clk, .host_tx(htx), .host_rx_ready(hrr), .host_rx(hrx),
      .host_tx_ready(htr));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rtx.valid === 1'b1) rq.push_back(rtx.data);
      if (urx.valid === 1'b1) uq.push_back(urx.data);
   end
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk(rdat, e);
   endtask
   task automatic wait_mode(input logic m);
      int i;
      for (i = 0; i < 400 && cmd !== m; i++) @(posedge clk);
      if (cmd !== m) begin
         fail_count++;
         finish_test();
      end
   endtask
   task automatic say(input string s);
      int i;
      for (i = 0; i < s.len(); i++) host_u.send(s[i]);
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      finish_test();
   end
   ////////////////////////////////////////
   initial begin
      int i, k, sum, bar;
      logic [7:0] b;
      logic [31:0] bw[4];
      logic [31:0] be[4];
      string rep;
      bw = '{32'd299, 32'd300, 32'd230401, 32'd230400};
      be = '{32'd9600, 32'd300, 32'd300, 32'd230400};
      rep = "NO CARRIER OK";
      rst = 1'b1;
      btn = 1'b1;
      {rrx, radio, lda, addr, wd, wr_s, rd_s} = '0;
      void'($urandom(32'hBC088286));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      btn <= 1'b0;
      #1 chk(cmd, 1'b1);
      chk(dbaud, `RMMC_DFLT_BAUD);
      chk(leds[4:0], 32'h0);
      rreg(`RMMC_OFF_ROLE, 32'h2);
      for (i = 0; i < 4; i++) begin
         wreg(`RMMC_OFF_ROLE, i);
         rreg(`RMMC_OFF_ROLE, i < 3 ? i : 2);
      end
      b = $urandom;
      wreg(`RMMC_OFF_NTYPE, b);
      rreg(`RMMC_OFF_NTYPE, b);
      for (i = 0; i < 4; i++) begin
         wreg(`RMMC_OFF_BAUD, bw[i]);
         rreg(`RMMC_OFF_BAUD, be[i]);
      end
      wreg(`RMMC_OFF_CTRL, 32'h1);
      #1 chk(r485, 1'b1);
      wreg(`RMMC_OFF_CTRL, 32'h0);
      rreg(4'hF, 32'h0);
      rreg(`RMMC_OFF_DIAG_BAUD, `RMMC_DIAG_BAUD);
      host_u.send(8'h51);
      chk(rq.size(), 0);
      say("ATA\015");
      wait_mode(1'b0);
      chk(cmd, 1'b0);
      chk(dbaud, 32'd230400);
      lda <= 1'b1;
      for (i = 0; i < 4; i++) begin
         b = $urandom;
         if (b == `RMMC_ESC_CHAR) b = 8'h2A;
         eq.push_back(b);
         host_u.send(b);
         rrx <= '{1'b1, ~b};
         @(posedge clk);
         rrx <= '{1'b0, b};
      end
      radio.synced <= 1'b1;
      for (i = 0; i < 6; i++) begin
         b = $urandom;
         lv.push_back(b);
         @(posedge clk);
         radio.pkt_valid <= 1'b1;
         radio.pkt_level <= b;
         @(posedge clk);
         radio.pkt_valid <= 1'b0;
      end
      sum = (lv[2] + lv[3] + lv[4] + lv[5]) / 4;
      bar = (sum >= 8'hC0) + (sum >= 8'h80) + (sum >= 8'h40);
      radio.transmitting <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(leds.strength, (1 << bar) - 1);
      chk(leds.rx_sync, 1'b1);
      chk(leds.tx, 1'b1);
      radio.transmitting <= 1'b0;
      chk(rq.size(), 4);
      for (k = 0; k < 4; k++) begin
         chk(rq[k], eq[k]);
         chk(uq[k], 8'(~eq[k]));
      end
      btn <= 1'b1;
      repeat (5) @(posedge clk);
      btn <= 1'b0;
      chk(cmd, 1'b0);
      rq.delete();
      repeat (GRD + 4) @(posedge clk);
      say("++x");
      repeat (20) @(posedge clk);
      chk(cmd, 1'b0);
      chk(rq.size(), 2);
      chk(rq[0], `RMMC_ESC_CHAR);
      chk(rq[1], `RMMC_ESC_CHAR);
      // Slow host proves the reply waits for ready
      host_u.slow <= 1'b1;
      repeat (GRD + 4) @(posedge clk);
      say("+++");
      repeat (GRD + 4) @(posedge clk);
      wait_mode(1'b1);
      // Reply runs at about half rate behind the slow host
      for (i = 0; i < 200 && host_u.got_q.size() < rep.len(); i++) @(posedge clk);
      chk(host_u.got_q.size(), rep.len());
      for (k = 0; k < rep.len(); k++) chk(host_u.got_q[k], rep[k]);
      repeat (2) @(posedge clk);
      #1 chk(leds[4:0], 32'h0);
      rreg(`RMMC_OFF_SIGNAL, bar);
      finish_test();
   end
endmodule // tb
`default_nettype wire

// [design/rmmc_top.sv]
// Purpose: Mode control, escape detection and indicator logic of a radio modem
// Assumes: Serial bytes arrive already framed; radio status arrives as levels
// Notes:   Registers are reached over a plain address/strobe port
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rmmc_defs.svh"

// What this block does
// - Button at power-up boots command mode, 9600
// - Guarded +++ gives NO CARRIER OK, command
// - Command mode blocks all user data
// - Command mode allows register read and write
// - Command mode lights only system status
// - ATA Enter returns to data mode
// - Data port rate 300 to 230400 bps
// - Diagnostic port fixed at 115200 bps
// - Transmit indicator lit while radio transmits
// - Receive indicator lit when synced and receiving
// - Strength bar from last four good packets
// - Strength readable in signal register
// - One data interface at a time
// - Master is sync source; passes no user data
// - Repeater stores, forwards, relays sync
// - Repeater with local device is also endpoint
// - Endpoint exchanges data with master
// - Role register selects network role
// - Type register selects network type
// - Strength bar cycles 300 ms while acquiring
// - Synced repeater splits hop between indicators
module rmmc_top
   import rmmc_pkg::*;
#(
   parameter int GUARD_CYCLES = `RMMC_CLK_HZ / 1000 * `RMMC_GUARD_MS,
   parameter int CYCLE_CYCLES = `RMMC_CLK_HZ / 1000 * `RMMC_CYCLE_MS
) (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     config_button,
   input  wire rmmc_byte_t               host_rx,
   output logic                          host_rx_ready,
   output rmmc_byte_t                    host_tx,
   input  wire logic                     host_tx_ready,
   output rmmc_byte_t                    radio_tx,
   input  wire rmmc_byte_t               radio_rx,
   output rmmc_byte_t                    user_rx,
   input  wire rmmc_radio_t              radio,
   input  wire logic                     local_device_attached,
   output rmmc_leds_t                    leds,
   output logic                          use_rs485,
   output logic [31:0]                   data_baud,
   output logic [31:0]                   diag_baud,
   output logic                          sync_source,
   output logic                          forward_en,
   output logic                          local_endpoint,
   output logic [1:0]                    role,
   output logic [7:0]                    network_type,
   output logic                          command_mode,
   input  wire logic [`RMMC_ADDR_W-1:0]  reg_addr,
   input  wire logic [31:0]              reg_wdata,
   input  wire logic                     reg_write,
   input  wire logic                     reg_read,
   output logic [31:0]                   reg_rdata
);

   initial begin
      if (GUARD_CYCLES < 2 || CYCLE_CYCLES < 2) begin
         $error("rmmc_top: timing counts too small");
      end
   end

   function automatic logic [1:0] strength_bar(input logic [9:0] sum);
      logic [7:0] avg;
      avg = sum[9:2];
      if (avg >= 8'hC0) strength_bar = 2'd3;
      else if (avg >= 8'h80) strength_bar = 2'd2;
      else if (avg >= 8'h40) strength_bar = 2'd1;
      else strength_bar = 2'd0;
   endfunction

   function automatic logic [2:0] bar_leds(input logic [1:0] n);
      unique case (n)
         2'd0: bar_leds = 3'b000;
         2'd1: bar_leds = 3'b001;
         2'd2: bar_leds = 3'b011;
         2'd3: bar_leds = 3'b111;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Mode and escape detection

   localparam logic [3:0] MSG_LEN = 4'd13;
   localparam logic [7:0] MSG [13] = '{8'h4E, 8'h4F, 8'h20, 8'h43, 8'h41, 8'h52, 8'h52,
                                       8'h49, 8'h45, 8'h52, 8'h20, 8'h4F, 8'h4B};

   rmmc_mode_t  mode_q, mode_d;
   logic [31:0] quiet_q, quiet_d;
   logic [1:0]  plus_q, plus_d;
   logic [3:0]  msg_q, msg_d;
   logic [1:0]  ata_q, ata_d;
   logic        flush_q, flush_d;
   logic [1:0]  flush_n_q, flush_n_d;
   logic        guard_ok;
   logic        host_in;

   assign guard_ok = (quiet_q >= 32'(GUARD_CYCLES));
   assign host_in  = host_rx.valid && host_rx_ready;
   assign command_mode = (mode_q != RMMC_M_DATA) && (mode_q != RMMC_M_ESC);
   // Held bytes are replayed one per cycle, so input stalls meanwhile
   assign host_rx_ready = !flush_q;

   always_comb begin
      mode_d    = mode_q;
      quiet_d   = host_in ? 32'd0 : (guard_ok ? quiet_q : quiet_q + 32'd1);
      plus_d    = plus_q;
      msg_d     = msg_q;
      ata_d     = ata_q;
      flush_d   = flush_q;
      flush_n_d = flush_n_q;
      if (flush_q) begin
         flush_n_d = flush_n_q - 2'd1;
         if (flush_n_q == 2'd1) flush_d = 1'b0;
      end
      unique case (mode_q)
         RMMC_M_BOOT: begin
            // Button is looked at only here, one cycle after reset
            mode_d = config_button ? RMMC_M_CMD : RMMC_M_DATA;
         end
         RMMC_M_CMD: begin
            if (host_in) begin
               if (ata_q == 2'd0 && host_rx.data == `RMMC_CH_A) ata_d = 2'd1;
               else if (ata_q == 2'd1 && host_rx.data == `RMMC_CH_T) ata_d = 2'd2;
               else if (ata_q == 2'd2 && host_rx.data == `RMMC_CH_A) ata_d = 2'd3;
               else if (ata_q == 2'd3 && host_rx.data == `RMMC_CR_CHAR) begin
                  ata_d  = 2'd0;
                  mode_d = RMMC_M_DATA;
               end else ata_d = 2'd0;
            end
         end
         RMMC_M_DATA: begin
            if (host_in && host_rx.data == `RMMC_ESC_CHAR && guard_ok) begin
               plus_d = 2'd1;
               mode_d = RMMC_M_ESC;
            end
         end
         RMMC_M_ESC: begin
            if (host_in) begin
               if (host_rx.data == `RMMC_ESC_CHAR && plus_q != 2'd3) begin
                  plus_d = plus_q + 2'd1;
               end else begin
                  // Give the held pluses back to the data path
                  flush_d   = 1'b1;
                  flush_n_d = plus_q;
                  plus_d    = 2'd0;
                  mode_d    = RMMC_M_DATA;
               end
            end else if (plus_q == 2'd3 && guard_ok) begin
               plus_d = 2'd0;
               msg_d  = 4'd0;
               mode_d = RMMC_M_REPLY;
            end
         end
         RMMC_M_REPLY: begin
            if (host_tx_ready) begin
               msg_d = msg_q + 4'd1;
               if (msg_q == MSG_LEN - 4'd1) mode_d = RMMC_M_CMD;
            end
         end
         default: mode_d = RMMC_M_BOOT;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q    <= RMMC_M_BOOT;
         quiet_q   <= 32'd0;
         plus_q    <= 2'd0;
         msg_q     <= 4'd0;
         ata_q     <= 2'd0;
         flush_q   <= 1'b0;
         flush_n_q <= 2'd0;
      end else begin
         mode_q    <= mode_d;
         quiet_q   <= quiet_d;
         plus_q    <= plus_d;
         msg_q     <= msg_d;
         ata_q     <= ata_d;
         flush_q   <= flush_d;
         flush_n_q <= flush_n_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   logic [1:0]  role_q, role_d;
   logic [7:0]  ntype_q, ntype_d;
   logic [31:0] baud_q, baud_d;
   logic        if_sel_q, if_sel_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  bar_q;
   // Remembers a forced boot so the port stays at the default rate
   logic        config_boot_q;

   always_comb begin
      role_d   = role_q;
      ntype_d  = ntype_q;
      baud_d   = baud_q;
      if_sel_d = if_sel_q;
      rdata_d  = 32'h0000_0000;
      if (reg_write && command_mode) begin
         unique case (reg_addr)
            `RMMC_OFF_CTRL:  if_sel_d = reg_wdata[`RMMC_CTRL_IF_BIT];
            `RMMC_OFF_ROLE:  if (reg_wdata[1:0] != 2'b11) role_d = reg_wdata[1:0];
            `RMMC_OFF_NTYPE: ntype_d = reg_wdata[7:0];
            `RMMC_OFF_BAUD: begin
               if (reg_wdata >= `RMMC_MIN_BAUD && reg_wdata <= `RMMC_MAX_BAUD) begin
                  baud_d = reg_wdata;
               end
            end
            default: ;
         endcase
      end
      if (reg_read && command_mode) begin
         unique case (reg_addr)
            `RMMC_OFF_CTRL:      rdata_d = {31'd0, if_sel_q};
            `RMMC_OFF_ROLE:      rdata_d = {30'd0, role_q};
            `RMMC_OFF_NTYPE:     rdata_d = {24'd0, ntype_q};
            `RMMC_OFF_BAUD:      rdata_d = baud_q;
            `RMMC_OFF_STATUS:    rdata_d = {28'd0, radio.synced, mode_q};
            `RMMC_OFF_SIGNAL:    rdata_d = {30'd0, bar_q};
            `RMMC_OFF_DIAG_BAUD: rdata_d = `RMMC_DIAG_BAUD;
            default:             rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         role_q   <= `RMMC_RST_ROLE;
         ntype_q  <= `RMMC_RST_NTYPE;
         baud_q   <= `RMMC_DFLT_BAUD;
         if_sel_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
      end else begin
         role_q   <= role_d;
         ntype_q  <= ntype_d;
         baud_q   <= baud_d;
         if_sel_q <= if_sel_d;
         rdata_q  <= rdata_d;
      end
   end

   assign reg_rdata    = rdata_q;
   assign role         = role_q;
   assign network_type = ntype_q;
   assign use_rs485    = if_sel_q;
   // Forced command mode always talks at the default rate
   assign data_baud    = (mode_q == RMMC_M_CMD && config_boot_q) ? `RMMC_DFLT_BAUD : baud_q;
   assign diag_baud    = `RMMC_DIAG_BAUD;
   assign sync_source  = (role_q == RMMC_ROLE_MASTER);
   assign forward_en   = (role_q == RMMC_ROLE_REPEATER) && !command_mode;
   assign local_endpoint = (role_q == RMMC_ROLE_ENDPOINT) ||
                           (role_q == RMMC_ROLE_REPEATER && local_device_attached);

   always_ff @(posedge clk) begin
      if (rst) config_boot_q <= 1'b0;
      else if (mode_q == RMMC_M_BOOT) config_boot_q <= config_button;
      else if (mode_q == RMMC_M_DATA) config_boot_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Data paths

   rmmc_byte_t radio_tx_q, user_rx_q, host_tx_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         radio_tx_q <= '0;
         user_rx_q  <= '0;
         host_tx_q  <= '0;
      end else begin
         // Pluses are held until the escape resolves
         radio_tx_q.valid <= (flush_q || (host_in && mode_q == RMMC_M_DATA &&
                              mode_d == RMMC_M_DATA)) && local_endpoint;
         radio_tx_q.data  <= flush_q ? `RMMC_ESC_CHAR : host_rx.data;
         user_rx_q.valid  <= radio_rx.valid && !command_mode && local_endpoint;
         user_rx_q.data   <= radio_rx.data;
         host_tx_q.valid  <= (mode_q == RMMC_M_REPLY) && host_tx_ready;
         host_tx_q.data   <= MSG[msg_q];
      end
   end
   assign radio_tx = radio_tx_q;
   assign user_rx  = user_rx_q;
   assign host_tx  = host_tx_q;

   ////////////////////////////////////////////////////////////////////////
   // Signal strength and indicators

   logic [7:0]  hist_q [4];
   logic [31:0] cyc_cnt_q;
   logic [1:0]  cyc_led_q;
   logic        heard_q;
   logic        acquiring;
   rmmc_leds_t  leds_d, leds_q;

   assign acquiring = !radio.synced || (role_q == RMMC_ROLE_MASTER && radio.fast_sync);

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) hist_q[i] <= 8'h00;
         bar_q     <= 2'd0;
         cyc_cnt_q <= 32'd0;
         cyc_led_q <= 2'd0;
         heard_q   <= 1'b0;
      end else begin
         // Stays set between packets; losing sync forgets it
         heard_q <= radio.synced && (heard_q || radio.pkt_valid);
         if (radio.pkt_valid) begin
            hist_q[0] <= radio.pkt_level;
            for (int i = 1; i < 4; i++) hist_q[i] <= hist_q[i-1];
            bar_q <= strength_bar({2'b00, radio.pkt_level} + {2'b00, hist_q[0]} +
                                  {2'b00, hist_q[1]} + {2'b00, hist_q[2]});
         end
         if (cyc_cnt_q >= 32'(CYCLE_CYCLES - 1)) begin
            cyc_cnt_q <= 32'd0;
            cyc_led_q <= (cyc_led_q == 2'd2) ? 2'd0 : cyc_led_q + 2'd1;
         end else begin
            cyc_cnt_q <= cyc_cnt_q + 32'd1;
         end
      end
   end

   always_comb begin
      leds_d = '0;
      leds_d.status = 1'b1;
      if (!command_mode) begin
         leds_d.tx      = radio.transmitting;
         leds_d.rx_sync = radio.synced && heard_q;
         if (role_q == RMMC_ROLE_REPEATER && radio.synced) begin
            leds_d.rx_sync = !radio.hop_second_half;
            leds_d.tx      = radio.hop_second_half;
         end
         if (acquiring) leds_d.strength = 3'b001 << cyc_led_q;
         else leds_d.strength = bar_leds(bar_q);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) leds_q <= '0;
      else leds_q <= leds_d;
   end
   assign leds = leds_q;

endmodule // rmmc_top
`default_nettype wire

// [inc/rmmc_defs.svh]
// Purpose: Constants for the radio modem mode controller
// Assumes: 50 MHz system clock
// Notes:   Offsets are register word indexes on the plain register port
`ifndef RMMC_DEFS_SVH
`define RMMC_DEFS_SVH
`define RMMC_CLK_HZ          50000000
`define RMMC_GUARD_MS        1000
`define RMMC_CYCLE_MS        300
`define RMMC_DFLT_BAUD       32'd9600
`define RMMC_DIAG_BAUD       32'd115200
`define RMMC_MIN_BAUD        32'd300
`define RMMC_MAX_BAUD        32'd230400
`define RMMC_ESC_CHAR        8'h2B
`define RMMC_CR_CHAR         8'h0D
`define RMMC_CH_A            8'h41
`define RMMC_CH_T            8'h54
`define RMMC_OFF_CTRL        4'h0
`define RMMC_OFF_ROLE        4'h1
`define RMMC_OFF_NTYPE       4'h2
`define RMMC_OFF_BAUD        4'h3
`define RMMC_OFF_STATUS      4'h4
`define RMMC_OFF_SIGNAL      4'h5
`define RMMC_OFF_DIAG_BAUD   4'h6
`define RMMC_CTRL_IF_BIT     0
`define RMMC_RST_ROLE        2'h2
`define RMMC_RST_NTYPE       8'h00
`define RMMC_ADDR_W          4
`endif

// [inc/rmmc_pkg.sv]
// Purpose: Types for the radio modem mode controller
// Assumes: Constants come from rmmc_defs.svh
// Notes:   None
package rmmc_pkg;
   typedef enum logic [1:0] {
      RMMC_ROLE_MASTER   = 2'b00,
      RMMC_ROLE_REPEATER = 2'b01,
      RMMC_ROLE_ENDPOINT = 2'b10
   } rmmc_role_t;
   typedef enum logic [2:0] {
      RMMC_M_BOOT   = 3'b000,
      RMMC_M_CMD    = 3'b001,
      RMMC_M_DATA   = 3'b010,
      RMMC_M_ESC    = 3'b011,
      RMMC_M_REPLY  = 3'b100
   } rmmc_mode_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } rmmc_byte_t;
   typedef struct packed {
      logic       status;
      logic       tx;
      logic       rx_sync;
      logic [2:0] strength;
   } rmmc_leds_t;
   typedef struct packed {
      logic       pkt_valid;
      logic [7:0] pkt_level;
      logic       synced;
      logic       transmitting;
      logic       hop_second_half;
      logic       fast_sync;
   } rmmc_radio_t;
endpackage
